// File: core/tcs_pkg.sv
package tcs_pkg;
   localparam logic [15:0] TCS_T1_CLKSEL_ADDR = 16'hFF8C;
   localparam logic [15:0] TCS_T2_CLKSEL_ADDR = 16'hFF5B;
   localparam logic [15:0] TCS_T1_MODE_ADDR   = 16'hFF43;
   localparam logic [15:0] TCS_T2_MODE_ADDR   = 16'hFFA0;
   localparam logic [7:0]  TCS_RESET_VAL      = 8'h00;
   localparam int          TCS_CE_BIT         = 7;
   localparam int          TCS_MODE_BIT       = 6;
   localparam int          TCS_LVS_BIT        = 3;
   localparam int          TCS_LVR_BIT        = 2;
   localparam int          TCS_INV_BIT        = 1;
   localparam int          TCS_OE_BIT         = 0;
   localparam logic [7:0]  TCS_T1_LARGE_MASK  = 8'hCF;
   localparam logic [7:0]  TCS_T1_SMALL_MASK  = 8'h80;
   localparam logic [7:0]  TCS_T2_MASK        = 8'h80;
   localparam logic [7:0]  TCS_WO_MASK        = 8'h0C;
   localparam int          TCS_PRE_W          = 12;
   typedef enum logic [2:0] {
      TCS_SEL_FALL = 3'h0, TCS_SEL_RISE = 3'h1, TCS_SEL_DIV1 = 3'h2, TCS_SEL_DIV2 = 3'h3,
      TCS_SEL_DIV16 = 3'h4, TCS_SEL_DIV64 = 3'h5, TCS_SEL_DIV256 = 3'h6, TCS_SEL_TOP = 3'h7
   } tcs_sel_t;
   typedef struct packed {
      logic        wr;
      logic        bit_wr;
      logic [2:0]  bit_idx;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } tcs_bus_t;
endpackage

// File: core/tcs_counter.sv
`timescale 1ns/1ps
module tcs_counter
   import tcs_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       enable,
   input  wire logic       tick,
   output logic [7:0]      count
);
   typedef struct packed {
      logic [7:0] cnt;
   } tcs_cnt_state_t;
   tcs_cnt_state_t s_reg;
   tcs_cnt_state_t s_next;
   always_comb begin
      s_next = s_reg;
      if (!enable) begin
         s_next.cnt = 8'h00;
      end else if (tick) begin
         s_next.cnt = s_reg.cnt + 8'h01;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
   assign count = s_reg.cnt;
   a_stop_clears: assert property (@(posedge mclk) disable iff (!rst_n)
      !enable |=> count == 8'h00) else $error("count not cleared when disabled");
   a_tick_adds: assert property (@(posedge mclk) disable iff (!rst_n)
      enable && tick |=> count == $past(count) + 8'h01) else $error("count did not step");
   a_hold_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      enable && !tick |=> $stable(count)) else $error("count moved without tick");
endmodule

// File: core/tcs_top.sv
`timescale 1ns/1ps
module tcs_top
   import tcs_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1
)(
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  tcs_pkg::tcs_bus_t      bus,
   input  wire logic [15:0]       rd_addr,
   input  wire logic              timer1_ext_clock_pin,
   input  wire logic              companion_timer_output,
   output logic [7:0]             rdata,
   output logic [7:0]             timer1_count,
   output logic [7:0]             timer2_count,
   output logic                   timer1_sel_invalid,
   output logic                   timer2_sel_invalid
);
   import tcs_pkg::*;
   typedef struct packed {
      logic [7:0]          t1_sel;
      logic [7:0]          t2_sel;
      logic [7:0]          t1_mode;
      logic [7:0]          t2_mode;
      logic [TCS_PRE_W-1:0] pre;
      logic                pin_q;
      logic                comp_q;
      logic                t1_tick;
      logic                t2_tick;
      logic [7:0]          rdata;
      logic                inv1;
      logic                inv2;
   } tcs_state_t;
   tcs_state_t s_reg;
   tcs_state_t s_next;
   logic [1:0]  rst_sync_reg;
   logic        rst_n;
   logic [7:0]  t1_mask;
   logic [TCS_PRE_W-1:0] pre_inc;
   logic        pin_rise;
   logic        pin_fall;
   logic        comp_rise;
   logic [7:0]  t1_cnt;
   logic [7:0]  t2_cnt;
   assign rst_n = rst_sync_reg[1];
   assign t1_mask = LARGE_PKG ? TCS_T1_LARGE_MASK : TCS_T1_SMALL_MASK;
   function automatic logic [7:0] wr_val(input logic [7:0] old, input tcs_bus_t b,
                                         input logic [7:0] mask);
      logic [7:0] v;
      v = old;
      if (b.bit_wr) begin
         v[b.bit_idx] = b.wdata[0];
      end else begin
         v = b.wdata;
      end
      return v & mask;
   endfunction
   function automatic logic pre_tick(input logic [2:0] code,
                                     input logic [TCS_PRE_W-1:0] nx,
                                     input logic [TCS_PRE_W-1:0] cur);
      logic [TCS_PRE_W-1:0] rise;
      rise = nx & ~cur;
      unique case (code)
         TCS_SEL_DIV1:   return 1'b1;
         TCS_SEL_DIV2:   return rise[0];
         TCS_SEL_DIV16:  return rise[3];
         TCS_SEL_DIV64:  return rise[5];
         TCS_SEL_DIV256: return rise[7];
         default:        return rise[11];
      endcase
   endfunction
   always_comb begin
      s_next = s_reg;
      // prescaler and pin edges
      pre_inc = s_reg.pre + {{(TCS_PRE_W-1){1'b0}}, 1'b1};
      s_next.pre = pre_inc;
      s_next.pin_q = timer1_ext_clock_pin;
      s_next.comp_q = companion_timer_output;
      pin_rise = timer1_ext_clock_pin && !s_reg.pin_q;
      pin_fall = !timer1_ext_clock_pin && s_reg.pin_q;
      comp_rise = companion_timer_output && !s_reg.comp_q;
      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            TCS_T1_CLKSEL_ADDR: s_next.t1_sel = wr_val(s_reg.t1_sel, bus, 8'h07);
            TCS_T2_CLKSEL_ADDR: s_next.t2_sel = wr_val(s_reg.t2_sel, bus, 8'h07);
            TCS_T1_MODE_ADDR:   s_next.t1_mode = wr_val(s_reg.t1_mode, bus, t1_mask);
            TCS_T2_MODE_ADDR:   s_next.t2_mode = wr_val(s_reg.t2_mode, bus, TCS_T2_MASK);
            default: ;
         endcase
      end
      // count clock selection
      unique case (s_reg.t1_sel[2:0])
         TCS_SEL_FALL: s_next.t1_tick = LARGE_PKG && pin_fall;
         TCS_SEL_RISE: s_next.t1_tick = LARGE_PKG && pin_rise;
         TCS_SEL_TOP:  s_next.t1_tick = comp_rise;
         default:      s_next.t1_tick = pre_tick(s_reg.t1_sel[2:0], pre_inc, s_reg.pre);
      endcase
      unique case (s_reg.t2_sel[2:0])
         TCS_SEL_FALL, TCS_SEL_RISE: s_next.t2_tick = 1'b0;
         default: s_next.t2_tick = pre_tick(s_reg.t2_sel[2:0], pre_inc, s_reg.pre);
      endcase
      s_next.inv1 = !LARGE_PKG && (s_reg.t1_sel[2:1] == 2'b00);
      s_next.inv2 = s_reg.t2_sel[2:1] == 2'b00;
      // read mux
      unique case (rd_addr)
         TCS_T1_CLKSEL_ADDR: s_next.rdata = s_reg.t1_sel;
         TCS_T2_CLKSEL_ADDR: s_next.rdata = s_reg.t2_sel;
         TCS_T1_MODE_ADDR:   s_next.rdata = s_reg.t1_mode & ~TCS_WO_MASK;
         TCS_T2_MODE_ADDR:   s_next.rdata = s_reg.t2_mode;
         default:            s_next.rdata = 8'h00;
      endcase
   end
   // reset synchroniser
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg.t1_sel  <= TCS_RESET_VAL;
         s_reg.t2_sel  <= TCS_RESET_VAL;
         s_reg.t1_mode <= TCS_RESET_VAL;
         s_reg.t2_mode <= TCS_RESET_VAL;
         s_reg.pre     <= '0;
         s_reg.pin_q   <= 1'b0;
         s_reg.comp_q  <= 1'b0;
         s_reg.t1_tick <= 1'b0;
         s_reg.t2_tick <= 1'b0;
         s_reg.rdata   <= 8'h00;
         s_reg.inv1    <= 1'b0;
         s_reg.inv2    <= 1'b0;
      end else begin
         s_reg.t1_sel  <= s_next.t1_sel;
         s_reg.t2_sel  <= s_next.t2_sel;
         s_reg.t1_mode <= s_next.t1_mode;
         s_reg.t2_mode <= s_next.t2_mode;
         s_reg.pre     <= s_next.pre;
         s_reg.pin_q   <= s_next.pin_q;
         s_reg.comp_q  <= s_next.comp_q;
         s_reg.t1_tick <= s_next.t1_tick;
         s_reg.t2_tick <= s_next.t2_tick;
         s_reg.rdata   <= s_next.rdata;
         s_reg.inv1    <= s_next.inv1;
         s_reg.inv2    <= s_next.inv2;
      end
   end
   // counters
   tcs_counter u_cnt1 (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .enable (s_reg.t1_mode[TCS_CE_BIT]),
      .tick   (s_reg.t1_tick),
      .count  (t1_cnt)
   );
   tcs_counter u_cnt2 (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .enable (s_reg.t2_mode[TCS_CE_BIT]),
      .tick   (s_reg.t2_tick),
      .count  (t2_cnt)
   );
   assign rdata = s_reg.rdata;
   assign timer1_count = t1_cnt;
   assign timer2_count = t2_cnt;
   assign timer1_sel_invalid = s_reg.inv1;
   assign timer2_sel_invalid = s_reg.inv2;
   // checks
   if (TCS_PRE_W < 12) begin : g_pre_check
      $error("prescaler too narrow for the slowest tap");
   end
   sequence t2_half_ticked;
      s_reg.t2_sel[2:0] == TCS_SEL_DIV2
      ##1 s_reg.t2_sel[2:0] == TCS_SEL_DIV2 && s_reg.t2_tick
      ##1 s_reg.t2_sel[2:0] == TCS_SEL_DIV2;
   endsequence
   sequence t2_half_gap;
      !s_reg.t2_tick ##1 s_reg.t2_tick;
   endsequence
   a_t2_div1: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.t2_sel[2:0] == 3'h2 |=> s_reg.t2_tick) else $error("div1 tick missing");
   a_t2_div2: assert property (@(posedge mclk) disable iff (!rst_n)
      t2_half_ticked |-> t2_half_gap) else $error("divide by two cadence broken");
   a_t2_code_idle: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.t2_sel[2:1] == 2'b00 |=> !s_reg.t2_tick) else $error("prohibited code ticked");
   a_t1_div1: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.t1_sel[2:0] == 3'h2 |=> s_reg.t1_tick) else $error("timer1 div1 tick missing");
   a_comp_rise: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.t1_sel[2:0] == 3'h7 && $rose(companion_timer_output)
      |=> s_reg.t1_tick) else $error("companion edge not counted");
   a_small_no_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      !LARGE_PKG && s_reg.t1_sel[2:1] == 2'b00 |=> !s_reg.t1_tick)
      else $error("prohibited timer1 code ticked");
   a_sel_mask: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.t2_sel[7:3] == 5'h00 && s_reg.t1_sel[7:3] == 5'h00)
      else $error("select high bits set");
   a_t1_wr_sel: assert property (@(posedge mclk) disable iff (!rst_n)
      bus.wr && !bus.bit_wr && bus.addr == TCS_T1_CLKSEL_ADDR
      |=> s_reg.t1_sel == ($past(bus.wdata) & 8'h07)) else $error("t1 select write lost");
   a_wr_t2: assert property (@(posedge mclk) disable iff (!rst_n)
      bus.wr && !bus.bit_wr && bus.addr == TCS_T2_CLKSEL_ADDR
      |=> s_reg.t2_sel == ($past(bus.wdata) & 8'h07)) else $error("t2 select write lost");
   a_read_t2: assert property (@(posedge mclk) disable iff (!rst_n)
      rd_addr == TCS_T2_CLKSEL_ADDR |=> rdata == $past(s_reg.t2_sel))
      else $error("t2 select read wrong");
   a_regs_reset: assert property (@(posedge mclk)
      !rst_n |-> s_reg.t2_sel == TCS_RESET_VAL && s_reg.t1_mode == TCS_RESET_VAL
      && s_reg.t2_mode == TCS_RESET_VAL) else $error("registers not cleared by reset");
   a_t1_bit_wr: assert property (@(posedge mclk) disable iff (!rst_n)
      bus.wr && bus.bit_wr && bus.addr == TCS_T1_MODE_ADDR
      |=> s_reg.t1_mode[$past(bus.bit_idx)]
          == ($past(bus.wdata[0]) & t1_mask[$past(bus.bit_idx)]))
      else $error("t1 mode bit write lost");
   a_t2_mode_ce: assert property (@(posedge mclk) disable iff (!rst_n)
      s_reg.t2_mode[6:0] == 7'h00) else $error("timer2 mode extra bits");
   a_t1_small_mask: assert property (@(posedge mclk) disable iff (!rst_n)
      !LARGE_PKG |-> s_reg.t1_mode[6:0] == 7'h00) else $error("timer1 mode extra bits");
   a_t2_ce_stop: assert property (@(posedge mclk) disable iff (!rst_n)
      !s_reg.t2_mode[TCS_CE_BIT] |=> timer2_count == 8'h00) else $error("timer2 not stopped");
   a_pin_fall: assert property (@(posedge mclk) disable iff (!rst_n)
      LARGE_PKG && s_reg.t1_sel[2:0] == 3'h0 && $fell(timer1_ext_clock_pin)
      |=> s_reg.t1_tick) else $error("falling edge not counted");
   a_pin_rise: assert property (@(posedge mclk) disable iff (!rst_n)
      LARGE_PKG && s_reg.t1_sel[2:0] == 3'h1 && $rose(timer1_ext_clock_pin)
      |=> s_reg.t1_tick) else $error("rising edge not counted");
endmodule

// File: verification/tcs_pin_model.sv
`timescale 1ns/1ps
// far side: timer input pin and companion timer output
module tcs_pin_model (
   input  wire logic mclk,
   output logic      pin,
   output logic      comp
);
   initial begin
      pin  = 1'b0;
      comp = 1'b0;
   end
   // each level held 4 cycles so the pin edge detector sees every edge
   task automatic pulse(input bit sel, input int n);
      repeat (n) begin
         repeat (4) @(posedge mclk);
         if (sel) comp <= 1'b1;
         else pin <= 1'b1;
         repeat (4) @(posedge mclk);
         if (sel) comp <= 1'b0;
         else pin <= 1'b0;
      end
   endtask
endmodule

// File: verification/tcs_top_bench.sv
`timescale 1ns/1ps
module tcs_top_bench;
   import tcs_pkg::*;
   logic        mclk;
   logic        arst_n;
   tcs_bus_t    bus;
   logic [15:0] rd_addr;
   logic        pin;
   logic        comp;
   logic [7:0]  rdata;
   logic [7:0]  c1;
   logic [7:0]  c2;
   logic        inv1;
   logic        inv2;
   logic [7:0]  rdata_s;
   logic [7:0]  c1s;
   logic        inv1s;
   int          num_errors;
   int          compares;
   int          dv [5] = '{1, 2, 16, 64, 256};
   logic [2:0]  xc [3] = '{3'h0, 3'h1, 3'h7};

   tcs_top #(.LARGE_PKG(1'b1)) dut_u (.mclk(mclk), .arst_n(arst_n), .bus(bus),
      .rd_addr(rd_addr), .timer1_ext_clock_pin(pin), .companion_timer_output(comp),
      .rdata(rdata), .timer1_count(c1), .timer2_count(c2),
      .timer1_sel_invalid(inv1), .timer2_sel_invalid(inv2));
   tcs_top #(.LARGE_PKG(1'b0)) dut_small_u (.mclk(mclk), .arst_n(arst_n), .bus(bus),
      .rd_addr(rd_addr), .timer1_ext_clock_pin(pin), .companion_timer_output(comp),
      .rdata(rdata_s), .timer1_count(c1s), .timer2_count(),
      .timer1_sel_invalid(inv1s), .timer2_sel_invalid());
   tcs_pin_model pin_u (.mclk(mclk), .pin(pin), .comp(comp));

   always #25 mclk = ~mclk;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{1'b1, 1'b0, 3'h0, a, d};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   task automatic bwr(input logic [15:0] a, input logic [2:0] i, input logic b);
      @(posedge mclk);
      bus <= '{1'b1, 1'b1, i, a, {7'h00, b}};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      rd_addr <= a;
      repeat (2) @(posedge mclk);
      #1;
      chk(rdata, exp);
   endtask
   // count delta over a span of cycles, or across n far-side pulses
   task automatic span(input bit t2, input int cyc, input int n, input bit sel,
                       input logic [7:0] exp);
      logic [7:0] c0;
      repeat (4) @(posedge mclk);
      #1;
      c0 = t2 ? c2 : c1;
      if (n > 0) pin_u.pulse(sel, n);
      else repeat (cyc) @(posedge mclk);
      if (n > 0) repeat (6) @(posedge mclk);
      #1;
      chk((t2 ? c2 : c1) - c0, exp);
   endtask
   task automatic complete_run();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #2000000;
      num_errors++;
      complete_run();
   end

   initial begin
      mclk = 1'b0;
      arst_n = 1'b0;
      bus = '0;
      rd_addr = '0;
      num_errors = 0;
      compares = 0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(TCS_T2_CLKSEL_ADDR, 8'h00);
      rd(TCS_T1_MODE_ADDR, 8'h00);
      rd(TCS_T2_MODE_ADDR, 8'h00);
      rd(16'hFF00, 8'h00);
      wr(TCS_T2_CLKSEL_ADDR, 8'hFF);
      rd(TCS_T2_CLKSEL_ADDR, 8'h07);
      wr(TCS_T1_MODE_ADDR, 8'hFF);
      rd(TCS_T1_MODE_ADDR, 8'hC3);
      chk(rdata_s, 8'h80);
      wr(TCS_T1_MODE_ADDR, 8'h00);
      wr(TCS_T2_MODE_ADDR, 8'hFF);
      rd(TCS_T2_MODE_ADDR, 8'h80);
      wr(TCS_T2_MODE_ADDR, 8'h00);
      wr(TCS_T2_CLKSEL_ADDR, 8'h00);
      bwr(TCS_T2_MODE_ADDR, 3'h7, 1'b1);
      span(1'b1, 20, 0, 1'b0, 8'h00);
      chk({7'h00, inv2}, 8'h01);
      bwr(TCS_T2_MODE_ADDR, 3'h7, 1'b0);
      for (int i = 0; i < 5; i++) begin
         wr(TCS_T2_CLKSEL_ADDR, 8'(i + 2));
         bwr(TCS_T2_MODE_ADDR, 3'h7, 1'b1);
         span(1'b1, 16 * dv[i], 0, 1'b0, 8'h10);
         chk({7'h00, inv2}, 8'h00);
         bwr(TCS_T2_MODE_ADDR, 3'h7, 1'b0);
         repeat (3) @(posedge mclk);
         #1;
         chk(c2, 8'h00);
      end
      wr(TCS_T2_CLKSEL_ADDR, 8'h07);
      bwr(TCS_T2_MODE_ADDR, 3'h7, 1'b1);
      span(1'b1, 8192, 0, 1'b0, 8'h02);
      bwr(TCS_T2_MODE_ADDR, 3'h7, 1'b0);
      wr(TCS_T1_CLKSEL_ADDR, 8'h02);
      wr(TCS_T1_MODE_ADDR, 8'h80);
      span(1'b0, 16, 0, 1'b0, 8'h10);
      wr(TCS_T1_MODE_ADDR, 8'h00);
      for (int k = 0; k < 3; k++) begin
         wr(TCS_T1_CLKSEL_ADDR, {5'h00, xc[k]});
         bwr(TCS_T1_MODE_ADDR, 3'h7, 1'b1);
         span(1'b0, 0, 5, k == 2, 8'h05);
         chk({7'h00, inv1}, 8'h00);
         chk(c1s, k == 2 ? 8'h05 : 8'h00);
         chk({7'h00, inv1s}, k == 2 ? 8'h00 : 8'h01);
         wr(TCS_T1_MODE_ADDR, 8'h00);
         repeat (3) @(posedge mclk);
         #1;
         chk(c1, 8'h00);
      end
      wr(TCS_T2_CLKSEL_ADDR, 8'h05);
      wr(TCS_T2_MODE_ADDR, 8'h80);
      wr(TCS_T1_MODE_ADDR, 8'h43);
      rd(TCS_T2_CLKSEL_ADDR, 8'h05);
      @(posedge mclk);
      arst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(TCS_T2_CLKSEL_ADDR, 8'h00);
      rd(TCS_T2_MODE_ADDR, 8'h00);
      rd(TCS_T1_MODE_ADDR, 8'h00);
      complete_run();
   end
endmodule
